// ===== include/timer_ff_defines.vh
// Constants for the timer output flip-flop and event flag block
//
// Functional notes
// - Control code 00 inverts, 01 sets, 10 clears, 11 leaves output flip-flop.
// - Bits 2/3 enable inverting the flip-flop on compare 0/1 match.
// - Bits 4/5 enable inverting the flip-flop on capture 0/1 load.
// - Compare 0 match sets status bit 0.
// - Compare 1 match sets status bit 1.
// - Counter overflow sets status bit 2.
// - Each event latches its flag and raises an interrupt request unless its mask bit is set.
// - Status read returns flags then clears them; unused bits read 0.
`ifndef TIMER_FF_DEFINES_VH
`define TIMER_FF_DEFINES_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_FF_CONTROL   8'h00
`define OFS_EVENT_STATUS 8'h04
`define OFS_IRQ_MASK     8'h08
`define OFS_IRQ_PENDING  8'h0C
`define OFS_FF_STATE     8'h10

// ---------------------------------------------------------------
// Register index codes used by the decoder
// ---------------------------------------------------------------
`define IDX_NONE    3'h0
`define IDX_CONTROL 3'h1
`define IDX_STATUS  3'h2
`define IDX_MASK    3'h3
`define IDX_PENDING 3'h4
`define IDX_STATE   3'h5

// ---------------------------------------------------------------
// Flip-flop control register fields
// ---------------------------------------------------------------
`define FFC_SOFT_LSB    0
`define FFC_SOFT_MSB    1
`define FFC_INV_LSB     2
`define FFC_INV_MSB     5
`define FFC_INV_CMP0    0
`define FFC_INV_CMP1    1
`define FFC_INV_CAP0    2
`define FFC_INV_CAP1    3
`define FFC_INV_RESET   4'h0
`define FFC_HIGH_LSB    6
`define FFC_HIGH_MSB    7
`define FFC_HIGH_READ   2'h3
`define SOFT_INVERT     2'h0
`define SOFT_SET        2'h1
`define SOFT_CLEAR      2'h2
`define SOFT_KEEP       2'h3

// ---------------------------------------------------------------
// Event flag layout, shared by status, mask and pending
// ---------------------------------------------------------------
`define EVT_CMP0     0
`define EVT_CMP1     1
`define EVT_OVF      2
`define EVT_COUNT    3
`define EVT_RESET    3'h0
`define MASK_RESET   3'h0
`define FF_RESET     1'h0

`endif

// ===== src/flag_bank.v
// Bank of sticky flags where a set always wins over a clear

module flag_bank #(
   parameter WIDTH = 3
) (
   input  wire             clk,
   input  wire             srst,
   input  wire [WIDTH-1:0] set_vec,
   input  wire [WIDTH-1:0] clr_vec,
   output wire [WIDTH-1:0] flags
);

   // ------------------------------------------------------------
   // One flop per flag
   // ------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
         // Each flop lives in its own slice so every bit has one driver
         reg flag_q;

         assign flags[i] = flag_q;

         // Set tested first so an event in the clear cycle survives
         always @(posedge clk) begin
            if (srst) begin
               flag_q <= 1'b0;
            end else if (set_vec[i]) begin
               flag_q <= 1'b1;
            end else if (clr_vec[i]) begin
               flag_q <= 1'b0;
            end
         end
      end
   endgenerate

endmodule

// ===== src/timer_ff_events.v
// Timer output flip-flop control, event status flags and APB register slave
`include "timer_ff_defines.vh"

module timer_ff_events (
   input  wire        CORE_CLK,
   input  wire        SRST,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output wire [31:0] PRDATA,
   output wire        PREADY,
   output wire        PSLVERR,
   input  wire        MATCH0,
   input  wire        MATCH1,
   input  wire        OVERFLOW,
   input  wire        CAPTURE0,
   input  wire        CAPTURE1,
   output wire        TIMER_FF,
   output wire        IRQ
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   reg  [3:0]            inv_en_q;
   reg  [3:0]            inv_en_d;
   reg                   ff_q;
   reg                   ff_d;
   reg  [2:0]            mask_q;
   reg  [2:0]            mask_d;
   reg  [31:0]           prdata_q;
   reg  [31:0]           prdata_d;
   reg  [2:0]            snap_q;
   reg  [2:0]            snap_d;
   reg                   err_q;
   reg                   err_d;
   wire [2:0]            setup_idx;
   wire [2:0]            access_idx;
   wire                  setup_phase;
   wire                  access_done;
   wire                  wr_done;
   wire                  rd_done;
   wire [`EVT_COUNT-1:0] events;
   wire [`EVT_COUNT-1:0] status;
   wire [`EVT_COUNT-1:0] pending;
   wire [`EVT_COUNT-1:0] status_clr;
   wire [`EVT_COUNT-1:0] pending_clr;
   wire [1:0]            soft_code;
   wire                  soft_write;
   wire                  hw_toggle;

   // ------------------------------------------------------------
   // Address decoder
   // ------------------------------------------------------------
   // Shared by the setup and access phases
   function [2:0] decode;
      input [7:0] addr;
      begin
         case (addr)
            `OFS_FF_CONTROL:   decode = `IDX_CONTROL;
            `OFS_EVENT_STATUS: decode = `IDX_STATUS;
            `OFS_IRQ_MASK:     decode = `IDX_MASK;
            `OFS_IRQ_PENDING:  decode = `IDX_PENDING;
            `OFS_FF_STATE:     decode = `IDX_STATE;
            default:           decode = `IDX_NONE;
         endcase
      end
   endfunction

   assign setup_idx  = decode(PADDR);
   assign access_idx = decode(PADDR);

   // ------------------------------------------------------------
   // APB phase tracking
   // ------------------------------------------------------------
   // Read data is prepared in setup so the access phase never waits
   assign setup_phase = PSEL & ~PENABLE;
   assign access_done = PSEL & PENABLE;
   assign wr_done     = access_done & PWRITE;
   assign rd_done     = access_done & ~PWRITE;
   assign PREADY      = 1'b1;
   assign PRDATA      = prdata_q;
   assign PSLVERR     = access_done & err_q;

   // ------------------------------------------------------------
   // Read data and error staging
   // ------------------------------------------------------------
   // Snapshot of status kept so only the flags returned are cleared
   always @* begin
      prdata_d = prdata_q;
      snap_d   = snap_q;
      err_d    = err_q;
      if (setup_phase) begin
         prdata_d = 32'h0000_0000;
         snap_d   = 3'h0;
         err_d    = (setup_idx == `IDX_NONE);
         if (!PWRITE) begin
            case (setup_idx)
               `IDX_CONTROL: begin
                  prdata_d[`FFC_HIGH_MSB:`FFC_HIGH_LSB] = `FFC_HIGH_READ;
                  prdata_d[`FFC_INV_MSB:`FFC_INV_LSB] = inv_en_q;
                  prdata_d[`FFC_SOFT_MSB:`FFC_SOFT_LSB] = `SOFT_KEEP;
               end
               `IDX_STATUS: begin
                  prdata_d[`EVT_COUNT-1:0] = status;
                  snap_d = status;
               end
               `IDX_MASK: begin
                  prdata_d[`EVT_COUNT-1:0] = mask_q;
               end
               `IDX_PENDING: begin
                  prdata_d[`EVT_COUNT-1:0] = pending;
               end
               `IDX_STATE: begin
                  prdata_d[0] = ff_q;
               end
               default: begin
                  prdata_d = 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // Bus-side flops
   always @(posedge CORE_CLK) begin
      if (SRST) begin
         prdata_q <= 32'h0000_0000;
         snap_q   <= 3'h0;
         err_q    <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         snap_q   <= snap_d;
         err_q    <= err_d;
      end
   end

   // ------------------------------------------------------------
   // Control and mask registers
   // ------------------------------------------------------------
   // Only the invert enables are stored; the soft code is an action
   always @* begin
      inv_en_d = inv_en_q;
      mask_d   = mask_q;
      if (wr_done && access_idx == `IDX_CONTROL) begin
         inv_en_d = PWDATA[`FFC_INV_MSB:`FFC_INV_LSB];
      end
      if (wr_done && access_idx == `IDX_MASK) begin
         mask_d = PWDATA[`EVT_COUNT-1:0];
      end
   end

   always @(posedge CORE_CLK) begin
      if (SRST) begin
         inv_en_q <= `FFC_INV_RESET;
         mask_q   <= `MASK_RESET;
      end else begin
         inv_en_q <= inv_en_d;
         mask_q   <= mask_d;
      end
   end

   // ------------------------------------------------------------
   // Output flip-flop
   // ------------------------------------------------------------
   assign soft_code  = PWDATA[`FFC_SOFT_MSB:`FFC_SOFT_LSB];
   assign soft_write = wr_done && (access_idx == `IDX_CONTROL) && (soft_code != `SOFT_KEEP);

   // Each enabled trigger inverts once; coincident triggers cancel in pairs
   assign hw_toggle = (MATCH0   & inv_en_q[`FFC_INV_CMP0])
                    ^ (MATCH1   & inv_en_q[`FFC_INV_CMP1])
                    ^ (CAPTURE0 & inv_en_q[`FFC_INV_CAP0])
                    ^ (CAPTURE1 & inv_en_q[`FFC_INV_CAP1]);

   // Software action takes priority over a hardware trigger
   always @* begin
      ff_d = ff_q;
      if (soft_write) begin
         case (soft_code)
            `SOFT_INVERT: ff_d = ~ff_q;
            `SOFT_SET:    ff_d = 1'b1;
            `SOFT_CLEAR:  ff_d = 1'b0;
            default:      ff_d = ff_q;
         endcase
      end else if (hw_toggle) begin
         ff_d = ~ff_q;
      end
   end

   always @(posedge CORE_CLK) begin
      if (SRST) begin
         ff_q <= `FF_RESET;
      end else begin
         ff_q <= ff_d;
      end
   end

   assign TIMER_FF = ff_q;

   // ------------------------------------------------------------
   // Event flags
   // ------------------------------------------------------------
   assign events[`EVT_CMP0] = MATCH0;
   assign events[`EVT_CMP1] = MATCH1;
   assign events[`EVT_OVF]  = OVERFLOW;

   // Status clears on the completing read, limited to flags returned
   assign status_clr = (rd_done && access_idx == `IDX_STATUS) ? snap_q : 3'h0;

   // Pending clears by writing ones
   assign pending_clr = (wr_done && access_idx == `IDX_PENDING) ?
                        PWDATA[`EVT_COUNT-1:0] : 3'h0;

   // Read-to-clear status flags
   flag_bank #(
      .WIDTH   (`EVT_COUNT)
   ) u_status (
      .clk     (CORE_CLK),
      .srst    (SRST),
      .set_vec (events),
      .clr_vec (status_clr),
      .flags   (status)
   );

   // Interrupt pending flags, independent of status reads
   flag_bank #(
      .WIDTH   (`EVT_COUNT)
   ) u_pending (
      .clk     (CORE_CLK),
      .srst    (SRST),
      .set_vec (events),
      .clr_vec (pending_clr),
      .flags   (pending)
   );

   // ------------------------------------------------------------
   // Interrupt output
   // ------------------------------------------------------------
   // Level request while any unmasked pending flag is set
   assign IRQ = |(pending & ~mask_q);

endmodule

// ===== verif/timer_ff_props.sv
// Port-level assertions for the timer flip-flop and event flag block
module timer_ff_props (
   input logic        CORE_CLK,
   input logic        SRST,
   input logic        PSEL,
   input logic        PENABLE,
   input logic        PWRITE,
   input logic [7:0]  PADDR,
   input logic [31:0] PWDATA,
   input logic [31:0] PRDATA,
   input logic        PSLVERR,
   input logic        MATCH0,
   input logic        MATCH1,
   input logic        OVERFLOW,
   input logic        CAPTURE0,
   input logic        CAPTURE1,
   input logic        TIMER_FF,
   input logic        IRQ
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Access decode and assertions
   // ------------------------------------------------------------
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SRST);
   wire acc    = PSEL && PENABLE;
   wire wr_ctl = acc && PWRITE && PADDR == 8'h00;
   wire rd_any = acc && !PWRITE;
   wire trig   = MATCH0 || MATCH1 || CAPTURE0 || CAPTURE1;

   soft_set_a: assert property (wr_ctl && PWDATA[1:0] == 2'h1 |=> TIMER_FF)
      else $error("flip-flop not set by software");
   soft_clear_a: assert property (wr_ctl && PWDATA[1:0] == 2'h2 |=> !TIMER_FF)
      else $error("flip-flop not cleared by software");
   soft_invert_a: assert property (wr_ctl && PWDATA[1:0] == 2'h0
      |=> TIMER_FF != $past(TIMER_FF)) else $error("flip-flop not inverted by software");
   quiet_hold_a: assert property (!trig && !(wr_ctl && PWDATA[1:0] != 2'h3)
      |=> $stable(TIMER_FF)) else $error("flip-flop moved without a cause");
   ctl_readback_a: assert property (rd_any && PADDR == 8'h00
      |-> PRDATA == {24'h0, 2'h3, PRDATA[5:2], 2'h3}) else $error("control read wrong");
   status_unused_a: assert property (rd_any && PADDR == 8'h04 |-> PRDATA[31:3] == 29'h0)
      else $error("unused status bits set");
   irq_hold_a: assert property ($fell(IRQ) && !$past(SRST) |-> $past(acc && PWRITE))
      else $error("request dropped without a write");
   irq_cause_a: assert property ($rose(IRQ)
      |-> $past(MATCH0 || MATCH1 || OVERFLOW || (acc && PWRITE))) else $error("request without event");
   err_phase_a: assert property (PSLVERR |-> acc) else $error("error outside access phase");
endmodule

bind timer_ff_events timer_ff_props timer_ff_props_inst (.CORE_CLK(CORE_CLK), .SRST(SRST),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .PRDATA(PRDATA), .PSLVERR(PSLVERR), .MATCH0(MATCH0), .MATCH1(MATCH1), .OVERFLOW(OVERFLOW),
   .CAPTURE0(CAPTURE0), .CAPTURE1(CAPTURE1), .TIMER_FF(TIMER_FF), .IRQ(IRQ));

// ===== verif/timer_flipflop_and_event_flags_bench.sv
// Self-checking bench for the timer flip-flop and event flag block
module timer_flipflop_and_event_flags_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Stimulus, design and reference model state
   // ------------------------------------------------------------
   logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, err, tff, irq;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [4:0]  ev = 5'h00;
   logic [15:0] lfsr = 16'h8146;
   logic [15:0] r;
   int          fail_count = 0, checks_done = 0, i;
   bit          ff;
   bit [3:0]    en;
   bit [2:0]    st, pend, msk;

   timer_ff_events timer_ff_events_inst (.CORE_CLK(clk), .SRST(srst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(err), .MATCH0(ev[0]), .MATCH1(ev[1]), .OVERFLOW(ev[2]),
      .CAPTURE0(ev[3]), .CAPTURE1(ev[4]), .TIMER_FF(tff), .IRQ(irq));

   // Clock, 4 ns period
   always #2 clk = ~clk;

   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Model step at one edge; clears are applied first so a set wins
   task automatic upd(input logic [4:0] e, input logic [1:0] code);
      int n;
      n = (e[0] & en[0]) + (e[1] & en[1]) + (e[3] & en[2]) + (e[4] & en[3]);
      case (code)
         2'h0: ff = !ff;
         2'h1: ff = 1'b1;
         2'h2: ff = 1'b0;
         default: ff = ff ^ n[0];
      endcase
      st |= e[2:0];
      pend |= e[2:0];
      #1;
      chk(tff, ff);
      chk(irq, |(pend & ~msk));
   endtask

   // One APB transfer; events e are pulsed during the access phase
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [4:0] e);
      logic [31:0] x;
      case (a)
         8'h00: x = {24'h0, 2'h3, en, 2'h3};
         8'h04: x = st;
         8'h08: x = msk;
         8'h0C: x = pend;
         8'h10: x = ff;
         default: x = 32'h0;
      endcase
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1; ev <= e;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      chk(err, a > 8'h10);
      psel <= 1'b0; penable <= 1'b0; ev <= 5'h00;
      if (!w) chk(rd, x);
      if (w && a == 8'h0C) pend &= ~d[2:0];
      if (!w && a == 8'h04) st &= ~x[2:0];
      // New mask gates the request at once; new enables act from the next edge
      if (w && a == 8'h08) msk = d[2:0];
      upd(e, (w && a == 8'h00) ? d[1:0] : 2'h3);
      if (w && a == 8'h00) en = d[5:2];
   endtask

   task automatic results();
      if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Watchdog sized well past the roughly nine hundred cycles of the run
   initial begin
      #40000;
      fail_count++;
      results();
   end

   // ------------------------------------------------------------
   // Main sequence: reset values, every soft code, random traffic
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      apb(1'b0, 8'h00, 32'h0, 5'h00);
      apb(1'b0, 8'h04, 32'h0, 5'h00);
      for (i = 0; i < 4; i++) apb(1'b1, 8'h00, {26'h0, 4'hF, i[1:0]}, 5'h01);
      for (i = 0; i < 300; i++) begin
         r = rnd();
         case (r[2:0])
            3'h0: apb(1'b1, 8'h00, {26'h0, r[13:8]}, r[15:11]);
            3'h1: apb(1'b0, 8'h04, 32'h0, r[15:11]);
            3'h2: apb(1'b1, 8'h08, {r, r}, 5'h00);
            3'h3: apb(1'b1, 8'h0C, {r, r}, r[15:11]);
            3'h4: apb(1'b0, {3'h0, r[5:3], 2'h0}, 32'h0, 5'h00);
            3'h5: apb(1'b1, 8'h04, {r, r}, 5'h00);
            default: begin
               @(posedge clk);
               ev <= r[15:11];
               @(posedge clk);
               ev <= 5'h00;
               upd(r[15:11], 2'h3);
            end
         endcase
      end
      results();
   end
endmodule
